// *** logic/pab_pkg.sv ***
// package of constants for the pin option register bank
// What this block does
// [RQ1] protection byte holds inverse of its config
// [RQ2] port1 bit 7 disables aux timer
// [RQ3] port1 config reset depends on variant
// [RQ4] port1 protection reset is complement
// [RQ5] software writes 0 to absent pin5
// [RQ6] software writes 0 to reserved bits
// [RQ7] software writes 1 to port2 bit 5
// [RQ8] port2 bit 6 disables adc hw trigger
// [RQ9] port2 config reset depends on variant
// [RQ10] port2 protection reset is complement
// [RQ11] small variant keeps port2 pins 1,4 high; the code resets its port2 to 8'h50, bit 1 low, and leaves bits 1,4 writable
// [RQ12] boot source field decoded to peripheral enables
// [RQ13] boot uart pin field decoded to scheme
// [RQ14] uart pin field ignored in cold config
// [RQ15] software writes 0 to boot reserved bits
package pab_pkg;
    // register indexes; the byte address is four times the index
    localparam logic [23:0] PAB_IDX_P0_INV  = 24'h004810;
    localparam logic [23:0] PAB_IDX_P1_CFG  = 24'h004811;
    localparam logic [23:0] PAB_IDX_P1_INV  = 24'h004812;
    localparam logic [23:0] PAB_IDX_P2_CFG  = 24'h004813;
    localparam logic [23:0] PAB_IDX_P2_INV  = 24'h004814;
    localparam logic [23:0] PAB_IDX_BOOT    = 24'h004815;
    localparam logic [23:0] PAB_IDX_BOOT_INV = 24'h004816;
    localparam logic [23:0] PAB_IDX_P0_CFG  = 24'h00480f;
    localparam int          PAB_ADDR_W      = 27;
    // field positions
    localparam int PAB_AUX_TIMER_BIT  = 7;
    localparam int PAB_ADC_TRIG_BIT   = 6;
    localparam int PAB_BOOT_SRC_LSB   = 0;
    localparam int PAB_BOOT_UART_LSB  = 4;
    // variant codes: 0 largest, 1 middle, 2 smallest
    localparam logic [1:0] PAB_VAR_LARGE  = 2'h0;
    localparam logic [1:0] PAB_VAR_MIDDLE = 2'h1;
    localparam logic [1:0] PAB_VAR_SMALL  = 2'h2;
    // reset values
    localparam logic [7:0] PAB_P0_CFG_RST   = 8'h00;
    localparam logic [7:0] PAB_P0_INV_RST   = 8'hff;
    localparam logic [7:0] PAB_P1_RST_LARGE = 8'h3f;
    localparam logic [7:0] PAB_P1_RST_MID   = 8'h1f;
    localparam logic [7:0] PAB_P1_RST_SMALL = 8'h0f;
    localparam logic [7:0] PAB_P2_RST_BIG   = 8'h7a;
    localparam logic [7:0] PAB_P2_RST_SMALL = 8'h50;
    localparam logic [7:0] PAB_BOOT_RST     = 8'h01;
    // writable bit masks, reserved bits read back their fixed value
    localparam logic [7:0] PAB_P0_WMASK   = 8'h3f;
    localparam logic [7:0] PAB_P1_WMASK   = 8'hbf;
    localparam logic [7:0] PAB_P2_WMASK   = 8'hda;
    localparam logic [7:0] PAB_BOOT_WMASK = 8'h33;
    // boot uart pin schemes
    typedef enum logic [1:0] {
        PAB_UART_SCAN = 2'h0,
        PAB_UART_P10  = 2'h1,
        PAB_UART_P32  = 2'h2,
        PAB_UART_P54  = 2'h3
    } pab_uart_t;
endpackage : pab_pkg

// *** logic/pab_boot_decode.sv ***
// decoder of the boot option byte into peripheral enables and uart scheme, the scheme taken from the port0 byte in cold config
`timescale 1ns/1ps
module pab_boot_decode
    import pab_pkg::*;
(
    // option inputs
    input  wire logic [7:0]  boot_byte,
    input  wire logic [7:0]  p0_cfg,
    input  wire logic        warm_config,
    // decoded selections
    output logic             boot_peripheral_zero,
    output logic             boot_peripheral_one,
    output logic             boot_scan_all,
    output pab_pkg::pab_uart_t boot_uart_scheme
);
    logic [1:0] src;
    logic [1:0] pins;
    // source enables from the two-bit field
    always_comb begin
        src = boot_byte[PAB_BOOT_SRC_LSB +: 2];
        boot_scan_all        = (src == 2'h0);                     // RQ12
        boot_peripheral_zero = src[0];                            // RQ12
        boot_peripheral_one  = src[1];                            // RQ12
    end
    // uart pins from option byte when warm, else from port0 byte
    always_comb begin
        if (warm_config) begin
            pins = boot_byte[PAB_BOOT_UART_LSB +: 2];             // RQ13
        end else begin
            pins = p0_cfg[5:4];                                   // RQ14
        end
        boot_uart_scheme = pab_uart_t'(pins);                     // RQ13
    end
endmodule : pab_boot_decode

// *** logic/pab_bank.sv ***
// apb register bank of pin alternate function and boot option bytes
`timescale 1ns/1ps
module pab_bank
    import pab_pkg::*;
#(
    parameter logic [1:0] VARIANT = pab_pkg::PAB_VAR_LARGE
)
(
    // apb slave
    input  wire logic                            pclk,
    input  wire logic                            presetn,
    input  wire logic                            psel,
    input  wire logic                            penable,
    input  wire logic                            pwrite,
    input  wire logic [pab_pkg::PAB_ADDR_W-1:0]  paddr,
    input  wire logic [31:0]                     pwdata,
    input  wire logic [3:0]                      pstrb,
    output logic [31:0]                          prdata,
    output logic                                 pready,
    output logic                                 pslverr,
    // boot state
    input  wire logic                            warm_config,
    // configuration outputs
    output logic [7:0]                           port0_select,
    output logic [7:0]                           port1_select,
    output logic [7:0]                           port2_select,
    output logic                                 aux_timer_disable,
    output logic                                 adc_hw_trigger_disable,
    output logic                                 boot_peripheral_zero,
    output logic                                 boot_peripheral_one,
    output logic                                 boot_scan_all,
    output pab_pkg::pab_uart_t                   boot_uart_pin_select,
    output logic                                 config_intact
);
    import pab_pkg::*;

    // variant reset values, protection is the complement
    localparam logic [7:0] P1_RST = (VARIANT == PAB_VAR_LARGE)  ?
        PAB_P1_RST_LARGE : (VARIANT == PAB_VAR_MIDDLE) ?
        PAB_P1_RST_MID : PAB_P1_RST_SMALL;                        // RQ3
    localparam logic [7:0] P2_RST = (VARIANT == PAB_VAR_SMALL) ?
        PAB_P2_RST_SMALL : PAB_P2_RST_BIG;                        // RQ9

    // elaboration check on variant code
    if (VARIANT > PAB_VAR_SMALL) begin : g_bad_variant
        $error("unsupported variant code");
    end

    // register index of the word address, top bit checked by the decode
    function automatic logic [23:0] word_idx(
        input logic [PAB_ADDR_W-1:0] a);
        word_idx = a[PAB_ADDR_W-2:2];
    endfunction : word_idx

    // apply a masked byte write keeping fixed bits
    function automatic logic [7:0] merge(input logic [7:0] old_v,
        input logic [7:0] new_v, input logic [7:0] mask);
        merge = (old_v & ~mask) | (new_v & mask);
    endfunction : merge

    logic [7:0]  p0_cfg_r, p0_cfg_nxt;
    logic [7:0]  p0_inv_r, p0_inv_nxt;
    logic [7:0]  p1_cfg_r, p1_cfg_nxt;
    logic [7:0]  p1_inv_r, p1_inv_nxt;
    logic [7:0]  p2_cfg_r, p2_cfg_nxt;
    logic [7:0]  p2_inv_r, p2_inv_nxt;
    logic [7:0]  boot_r, boot_nxt;
    logic [7:0]  boot_inv_r, boot_inv_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic        pready_r, pready_nxt;
    logic        pslverr_r, pslverr_nxt;
    logic        intact_r, intact_nxt;
    logic        wr, rd, hit;
    logic [23:0] idx;
    logic [7:0]  wb, rb;
    logic        dec_zero, dec_one, dec_scan;
    pab_uart_t   dec_uart;

    // boot option decoding
    pab_boot_decode u_boot (
        .boot_byte            (boot_r),
        .p0_cfg               (p0_cfg_r),
        .warm_config          (warm_config),
        .boot_peripheral_zero (dec_zero),
        .boot_peripheral_one  (dec_one),
        .boot_scan_all        (dec_scan),
        .boot_uart_scheme     (dec_uart)
    );

    // access decode; one wait state, answer in second access cycle
    always_comb begin
        idx = word_idx(paddr);
        wr  = psel & penable & pwrite & ~pready_r;
        rd  = psel & penable & ~pwrite & ~pready_r;
        wb  = pstrb[0] ? pwdata[7:0] : 8'h00;
        hit = ~paddr[PAB_ADDR_W-1];  // no alias above the index range
        rb  = 8'h00;
        unique case (idx)
            PAB_IDX_P0_CFG:   rb = p0_cfg_r;
            PAB_IDX_P0_INV:   rb = p0_inv_r;
            PAB_IDX_P1_CFG:   rb = p1_cfg_r;
            PAB_IDX_P1_INV:   rb = p1_inv_r;
            PAB_IDX_P2_CFG:   rb = p2_cfg_r;
            PAB_IDX_P2_INV:   rb = p2_inv_r;
            PAB_IDX_BOOT:     rb = boot_r;
            PAB_IDX_BOOT_INV: rb = boot_inv_r;
            default:          hit = 1'b0;
        endcase
    end

    // register next values
    always_comb begin
        p0_cfg_nxt   = p0_cfg_r;
        p0_inv_nxt   = p0_inv_r;
        p1_cfg_nxt   = p1_cfg_r;
        p1_inv_nxt   = p1_inv_r;
        p2_cfg_nxt   = p2_cfg_r;
        p2_inv_nxt   = p2_inv_r;
        boot_nxt     = boot_r;
        boot_inv_nxt = boot_inv_r;
        if (wr && hit && pstrb[0]) begin
            unique case (idx)
                PAB_IDX_P0_CFG:   p0_cfg_nxt = merge(p0_cfg_r, wb,
                                      PAB_P0_WMASK);
                PAB_IDX_P0_INV:   p0_inv_nxt = merge(p0_inv_r, wb,
                                      PAB_P0_WMASK);
                PAB_IDX_P1_CFG:   p1_cfg_nxt = merge(p1_cfg_r, wb,
                                      PAB_P1_WMASK);      // RQ6
                PAB_IDX_P1_INV:   p1_inv_nxt = merge(p1_inv_r, wb,
                                      PAB_P1_WMASK);
                PAB_IDX_P2_CFG:   p2_cfg_nxt = merge(p2_cfg_r, wb,
                                      PAB_P2_WMASK);      // RQ7
                PAB_IDX_P2_INV:   p2_inv_nxt = merge(p2_inv_r, wb,
                                      PAB_P2_WMASK);
                PAB_IDX_BOOT:     boot_nxt = merge(boot_r, wb,
                                      PAB_BOOT_WMASK);    // RQ15
                PAB_IDX_BOOT_INV: boot_inv_nxt = merge(boot_inv_r, wb,
                                      PAB_BOOT_WMASK);
                default:          boot_nxt = boot_r;
            endcase
        end
    end

    // bus answer next values
    always_comb begin
        pready_nxt  = psel & penable & ~pready_r;
        pslverr_nxt = (wr | rd) & ~hit;
        prdata_nxt  = 32'h0000_0000;
        if (rd && hit) begin
            prdata_nxt = {24'h00_0000, rb};
        end
    end

    // each config byte checked against its inverse
    always_comb begin
        intact_nxt = ((p0_cfg_nxt ^ p0_inv_nxt) == 8'hff) &&
                     ((p1_cfg_nxt ^ p1_inv_nxt) == 8'hff) &&
                     ((p2_cfg_nxt ^ p2_inv_nxt) == 8'hff) &&
                     ((boot_nxt ^ boot_inv_nxt) == 8'hff);  // RQ1
    end

    // state registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            p0_cfg_r   <= PAB_P0_CFG_RST;
            p0_inv_r   <= PAB_P0_INV_RST;
            p1_cfg_r   <= P1_RST;                                  // RQ3
            p1_inv_r   <= ~P1_RST;                                 // RQ4
            p2_cfg_r   <= P2_RST;                                  // RQ9
            p2_inv_r   <= ~P2_RST;                                 // RQ10
            boot_r     <= PAB_BOOT_RST;
            boot_inv_r <= ~PAB_BOOT_RST;
            prdata_r   <= 32'h0000_0000;
            pready_r   <= 1'b0;
            pslverr_r  <= 1'b0;
            intact_r   <= 1'b1;
        end else begin
            p0_cfg_r   <= p0_cfg_nxt;
            p0_inv_r   <= p0_inv_nxt;
            p1_cfg_r   <= p1_cfg_nxt;
            p1_inv_r   <= p1_inv_nxt;
            p2_cfg_r   <= p2_cfg_nxt;
            p2_inv_r   <= p2_inv_nxt;
            boot_r     <= boot_nxt;
            boot_inv_r <= boot_inv_nxt;
            prdata_r   <= prdata_nxt;
            pready_r   <= pready_nxt;
            pslverr_r  <= pslverr_nxt;
            intact_r   <= intact_nxt;
        end
    end

    // output flops for the steering signals
    logic [7:0] p0_o_r, p1_o_r, p2_o_r;
    logic       aux_o_r, adc_o_r, z_o_r, o_o_r, s_o_r;
    pab_uart_t  u_o_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            p0_o_r  <= PAB_P0_CFG_RST;
            p1_o_r  <= P1_RST;
            p2_o_r  <= P2_RST;
            aux_o_r <= P1_RST[PAB_AUX_TIMER_BIT];
            adc_o_r <= P2_RST[PAB_ADC_TRIG_BIT];
            z_o_r   <= 1'b1;
            o_o_r   <= 1'b0;
            s_o_r   <= 1'b0;
            u_o_r   <= PAB_UART_SCAN;
        end else begin
            p0_o_r  <= p0_cfg_r;
            p1_o_r  <= p1_cfg_r;
            p2_o_r  <= p2_cfg_r;
            aux_o_r <= p1_cfg_r[PAB_AUX_TIMER_BIT];                // RQ2
            adc_o_r <= p2_cfg_r[PAB_ADC_TRIG_BIT];                 // RQ8
            z_o_r   <= dec_zero;
            o_o_r   <= dec_one;
            s_o_r   <= dec_scan;
            u_o_r   <= dec_uart;
        end
    end

    // port drive
    assign prdata                 = prdata_r;
    assign pready                 = pready_r;
    assign pslverr                = pslverr_r;
    assign port0_select           = p0_o_r;
    assign port1_select           = p1_o_r;
    assign port2_select           = p2_o_r;
    assign aux_timer_disable      = aux_o_r;
    assign adc_hw_trigger_disable = adc_o_r;
    assign boot_peripheral_zero   = z_o_r;
    assign boot_peripheral_one    = o_o_r;
    assign boot_scan_all          = s_o_r;
    assign boot_uart_pin_select   = u_o_r;
    assign config_intact          = intact_r;
endmodule : pab_bank

// *** sim/pab_bank_checker.sv ***
// assertions on the option bank bus timing and outputs
`timescale 1ns/1ps
module pab_bank_checker
    import pab_pkg::*;
(
    // apb side
    input wire logic                        pclk,
    input wire logic                        presetn,
    input wire logic                        psel,
    input wire logic                        penable,
    input wire logic                        pwrite,
    input wire logic [PAB_ADDR_W-1:0]       paddr,
    input wire logic [31:0]                 pwdata,
    input wire logic [3:0]                  pstrb,
    input wire logic                        pready,
    input wire logic                        pslverr,
    // option side
    input wire logic                        warm_config,
    input wire logic [7:0]                  port0_select,
    input wire logic [7:0]                  port1_select,
    input wire logic                        aux_timer_disable,
    input wire logic                        adc_hw_trigger_disable,
    input wire logic                        boot_peripheral_zero,
    input wire logic                        boot_peripheral_one,
    input wire logic                        boot_scan_all,
    input wire pab_pkg::pab_uart_t          boot_uart_pin_select
);
    localparam logic [26:0] P1_ADDR = {1'b0, PAB_IDX_P1_CFG, 2'b00};
    localparam logic [26:0] P2_ADDR = {1'b0, PAB_IDX_P2_CFG, 2'b00};
    logic take_w;
    // write taken in the first access cycle
    assign take_w = psel && penable && !pready && pwrite && pstrb[0];
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // one wait state, then a single-cycle answer
    ready_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held too long");
    idle_ready_a: assert property (!(psel && penable) |=> !pready)
        else $error("pready without access");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    // written fields show two clocks after the take
    p1_select_a: assert property (take_w && paddr == P1_ADDR
        |-> ##2 port1_select == ($past(pwdata[7:0], 2) & 8'hbf))
        else $error("port1 select wrong");
    aux_timer_a: assert property (take_w && paddr == P1_ADDR
        |-> ##2 aux_timer_disable == $past(pwdata[7], 2))
        else $error("aux timer disable wrong");
    adc_trig_a: assert property (take_w && paddr == P2_ADDR
        |-> ##2 adc_hw_trigger_disable == $past(pwdata[6], 2))
        else $error("adc trigger disable wrong");
    scan_all_a: assert property (
        boot_scan_all == !(boot_peripheral_zero || boot_peripheral_one))
        else $error("boot scan decode wrong");
    uart_cold_a: assert property (!$past(warm_config)
        |-> boot_uart_pin_select == port0_select[5:4])
        else $error("cold uart pins wrong");
endmodule : pab_bank_checker

bind pab_bank pab_bank_checker u_pab_bank_checker (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .pready, .pslverr, .warm_config, .port0_select, .port1_select,
    .aux_timer_disable, .adc_hw_trigger_disable, .boot_peripheral_zero,
    .boot_peripheral_one, .boot_scan_all, .boot_uart_pin_select
);

// *** sim/tb_pab_bank.sv ***
// self-checking bench of the pin option register bank
`timescale 1ns/1ps
module tb_pab_bank;
    import pab_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, warm_config;
    logic        pready, pslverr, aux_timer_disable, adc_hw_trigger_disable;
    logic        boot_peripheral_zero, boot_peripheral_one, boot_scan_all;
    logic        config_intact, err;
    logic [26:0] paddr;
    logic [31:0] pwdata, prdata, prdata_s, prdata_m, rd, rds, rds_m;
    logic [3:0]  pstrb;
    logic [7:0]  port0_select, port1_select, port2_select;
    pab_uart_t   boot_uart_pin_select;
    int          num_errors = 0;
    int          check_count = 0;
    // reset image of all three variants
    logic [23:0] ridx [8] = '{PAB_IDX_P0_CFG, PAB_IDX_P0_INV, PAB_IDX_P1_CFG,
        PAB_IDX_P1_INV, PAB_IDX_P2_CFG, PAB_IDX_P2_INV, PAB_IDX_BOOT,
        PAB_IDX_BOOT_INV};
    logic [7:0]  rbig [8] = '{8'h00, 8'hff, 8'h3f, 8'hc0, 8'h7a, 8'h85,
        8'h01, 8'hfe};
    logic [7:0]  rsml [8] = '{8'h00, 8'hff, 8'h0f, 8'hf0, 8'h50, 8'haf,
        8'h01, 8'hfe};
    logic [7:0]  rmid [8] = '{8'h00, 8'hff, 8'h1f, 8'he0, 8'h7a, 8'h85,
        8'h01, 8'hfe};

    pab_bank u_pab_bank (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .warm_config, .port0_select,
        .port1_select, .port2_select, .aux_timer_disable,
        .adc_hw_trigger_disable, .boot_peripheral_zero, .boot_peripheral_one,
        .boot_scan_all, .boot_uart_pin_select, .config_intact
    );
    // other variants share the bus, only their read data is watched
    pab_bank #(.VARIANT(PAB_VAR_SMALL)) u_pab_bank_small (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata(prdata_s), .pready(), .pslverr(), .warm_config,
        .port0_select(), .port1_select(), .port2_select(),
        .aux_timer_disable(), .adc_hw_trigger_disable(),
        .boot_peripheral_zero(), .boot_peripheral_one(), .boot_scan_all(),
        .boot_uart_pin_select(), .config_intact()
    );
    pab_bank #(.VARIANT(PAB_VAR_MIDDLE)) u_pab_bank_mid (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata(prdata_m), .pready(), .pslverr(), .warm_config,
        .port0_select(), .port1_select(), .port2_select(),
        .aux_timer_disable(), .adc_hw_trigger_disable(),
        .boot_peripheral_zero(), .boot_peripheral_one(), .boot_scan_all(),
        .boot_uart_pin_select(), .config_intact()
    );

    // clock of 4 ns
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task automatic stop_test();
        if (num_errors == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // one apb transfer, request held until pready is sampled
    task automatic apb(input logic wr, input logic [23:0] idx,
                       input logic [7:0] wd, input logic [3:0] st);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= {1'b0, idx, 2'b00};
        pwdata <= {24'h0, wd};
        pstrb  <= st;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd  = prdata;
        rds = prdata_s;
        rds_m = prdata_m;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // let a write reach the option outputs
    task automatic settle();
        @(posedge pclk);
        #1;
    endtask : settle

    // main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = '0;
        warm_config = 1'b1;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, ridx[i], 8'h00, 4'h0);
            chk("large reset", rbig[i], rd);
            chk("small reset", rsml[i], rds);
            chk("middle reset", rmid[i], rds_m);
        end
        chk("intact at reset", 1, config_intact);
        chk("boot zero at reset", 1, boot_peripheral_zero);
        // port1 timer off, inverse out of step then restored
        apb(1'b1, PAB_IDX_P1_CFG, 8'h8f, 4'h1);
        settle();
        chk("aux timer off", 1, aux_timer_disable);
        chk("intact broken", 0, config_intact);
        apb(1'b1, PAB_IDX_P1_INV, 8'h30, 4'h1);
        settle();
        chk("intact restored", 1, config_intact);
        apb(1'b1, PAB_IDX_P1_CFG, 8'h0f, 4'h0);
        settle();
        chk("aux no strobe", 1, aux_timer_disable);
        apb(1'b1, PAB_IDX_P1_CFG, 8'h0f, 4'h1);
        settle();
        chk("aux timer on", 0, aux_timer_disable);
        // port2 adc trigger gate
        apb(1'b1, PAB_IDX_P2_CFG, 8'h72, 4'h1);
        settle();
        chk("adc trigger off", 1, adc_hw_trigger_disable);
        chk("port2 select", 8'h72, port2_select);
        apb(1'b1, PAB_IDX_P2_CFG, 8'h32, 4'h1);
        settle();
        chk("adc trigger on", 0, adc_hw_trigger_disable);
        // every boot source and uart pin code
        for (int s = 0; s < 4; s++) begin
            for (int u = 0; u < 4; u++) begin
                apb(1'b1, PAB_IDX_BOOT, 8'(u * 16 + s), 4'h1);
                settle();
                chk("boot zero", s % 2, boot_peripheral_zero);
                chk("boot one", s / 2, boot_peripheral_one);
                chk("boot scan", s == 0, boot_scan_all);
                chk("uart pins", u, boot_uart_pin_select);
            end
        end
        // cold config takes pins from port0
        @(posedge pclk);
        warm_config <= 1'b0;
        apb(1'b1, PAB_IDX_P0_CFG, 8'h20, 4'h1);
        settle();
        chk("cold uart", PAB_UART_P32, boot_uart_pin_select);
        chk("port0 select", 8'h20, port0_select);
        apb(1'b1, 24'h004817, 8'h5a, 4'h1);
        chk("unmapped error", 1, err);
        chk("unmapped data", 0, rd);
        stop_test();
    end

    // watchdog
    initial begin
        repeat (3000) @(posedge pclk);
        num_errors++;
        stop_test();
    end
endmodule : tb_pab_bank
